// ### dv/p0ps_periph_model.sv
// Purpose: Peripheral controllers standing behind the upper port 0 pins
// Assumes: One clock; outputs change just after the rising edge
// Notes:   Every output moves often, so a stale route cannot hide
`timescale 1ns/100ps

module p0ps_periph_model (
   // System
   input  wire        clock,
   input  wire        sys_rst,
   // Timer match outputs
   output logic [3:0] timer0Match,
   output logic [3:2] timer1Match,
   // Second serial port drive
   output logic       spi2SckOut,
   output logic       spi2SckOe,
   output logic       spi2MisoOut,
   output logic       spi2MisoOe,
   output logic       spi2MosiOut,
   output logic       spi2MosiOe,
   // Pulse width and CAN transmit
   output logic       pulse_width_output_5,
   output logic       can3_transmit_line,
   output logic       can2_transmit_line
);
   logic [14:0] phase;

   // Odd step keeps every bit toggling on its own rhythm
   always_ff @(posedge clock or posedge sys_rst) begin
      phase <= sys_rst ? 15'h0000 : phase + 15'h1a57;
   end

   assign {timer0Match, timer1Match, spi2SckOut, spi2SckOe, spi2MisoOut,
           spi2MisoOe, spi2MosiOut, spi2MosiOe, pulse_width_output_5,
           can3_transmit_line, can2_transmit_line} = phase;
endmodule // p0ps_periph_model

// ### dv/p0ps_pin_mux_monitor.sv
// Purpose: Concurrent checks on the upper port 0 function select block
// Assumes: Shadow copy of the select word follows taken bus writes
// Notes:   Reserved codes of pins 23 to 25 are not judged
`timescale 1ns/100ps

module p0ps_pin_mux_monitor (
   // System
   input wire        clock,
   input wire        sys_rst,
   // Wishbone
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0]  wb_sel_i,
   input wire        wb_we_i,
   input wire        wb_stb_i,
   input wire        wb_cyc_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // Pins and routes
   input wire [15:0] gpioOut,
   input wire [15:0] gpioDir,
   input wire [15:0] padIn,
   input wire [15:0] padOut,
   input wire [15:0] padOe,
   input wire        external_interrupt_line_0,
   input wire        spi2SckOut,
   input wire        spi2SckOe,
   input wire        can2_transmit_line,
   input wire [3:0]  analogSelect
);
   localparam logic [31:0] HI = 32'he002c004;
   logic [31:0] shadow;
   logic [15:0] gm;
   wire         take = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Shadow of the select word, byte lanes honoured
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         shadow <= 32'h15400000;
      end else if (take && wb_we_i && wb_adr_i == HI) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               shadow[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end
      end
   end

   // Pins in GPIO mode; pins 26 and 31 never are
   always_comb begin
      for (int k = 0; k < 16; k++) begin
         gm[k] = shadow[2*k +: 2] == 2'h0 && k != 10 && k != 15;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence rdHigh;
      take && !wb_we_i && wb_adr_i == HI;
   endsequence
   sequence rdOther;
      take && !wb_we_i && wb_adr_i != HI;
   endsequence

   ack_follows_a: assert property (take |=> wb_ack_o)
      else $error("ack missing after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   read_back_a: assert property (rdHigh |=> wb_dat_o == shadow)
      else $error("read data differs from written word");
   unmapped_zero_a: assert property (rdOther |=> wb_dat_o == 0)
      else $error("unmapped read not zero");
   gpio_path_a: assert property (((padOe ^ gpioDir) & gm) == 0
      && ((padOut ^ gpioOut) & gm) == 0)
      else $error("GPIO pin not following GPIO block");
   reserved_pin_a: assert property (!padOe[10] && !padOe[15])
      else $error("reserved pin driven");
   analog_sel_a: assert property (analogSelect ==
      {shadow[29:28] == 2'h1, shadow[27:26] == 2'h1,
       shadow[25:24] == 2'h1, shadow[23:22] == 2'h1})
      else $error("analog select wrong");
   reset_value_a: assert property ($fell(sys_rst) |->
      analogSelect == 4'hf && padOe[14:11] == 4'h0)
      else $error("reset selection wrong");
   eint_route_a: assert property (shadow[1:0] == 2'h1 |->
      external_interrupt_line_0 == padIn[0] && !padOe[0])
      else $error("interrupt 0 route wrong");
   can2_out_a: assert property (shadow[17:16] == 2'h1 |->
      padOe[8] && padOut[8] == can2_transmit_line)
      else $error("CAN 2 transmit route wrong");
   spi_clock_a: assert property (shadow[3:2] == 2'h2 |->
      padOe[1] == spi2SckOe && padOut[1] == spi2SckOut)
      else $error("serial clock route wrong");
endmodule // p0ps_pin_mux_monitor

bind p0ps_pin_mux p0ps_pin_mux_monitor u_mon (.clock, .sys_rst, .wb_adr_i,
   .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_dat_o,
   .wb_ack_o, .gpioOut, .gpioDir, .padIn, .padOut, .padOe,
   .external_interrupt_line_0, .spi2SckOut, .spi2SckOe,
   .can2_transmit_line, .analogSelect);

// ### dv/p0ps_pin_mux_tb_top.sv
// Purpose: Self-checking bench for the upper port 0 function select
// Assumes: Classic Wishbone single cycles; pins are combinational
// Notes:   Reserved codes of pins 23 to 25 are never written
`timescale 1ns/100ps

module p0ps_pin_mux_tb_top;
   typedef struct packed {
      logic [31:0] d;
      logic [3:0]  s;
      logic [31:0] r;
      logic [3:0]  a;
   } p0ps_row_t;
   localparam logic [31:0] HI = 32'he002c004;
   p0ps_row_t rows [6] = '{
      '{32'h00000000, 4'hf, 32'h00000000, 4'h0},
      '{32'h15455555, 4'hf, 32'h15455555, 4'hf},
      '{32'h2a802aaa, 4'hf, 32'h2a802aaa, 4'h0},
      '{32'h00c00000, 4'h4, 32'h2ac02aaa, 4'h0},
      '{32'h15400000, 4'hc, 32'h15402aaa, 4'hf},
      '{32'h000000ff, 4'h1, 32'h15402aff, 4'hf}};
   logic clock = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0;
   logic wb_stb_i = 1'b0, wb_cyc_i = 1'b0, wb_ack_o;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
   logic [3:0]  wb_sel_i = 4'h0, analogSelect, timer0Match, timer0Capture;
   logic [15:0] gpioOut = 16'hc35a, gpioDir = 16'h0000, padIn = 16'h36c9;
   logic [15:0] gpioIn, padOut, padOe;
   logic [3:2]  timer1Match, timer1Capture;
   logic external_interrupt_line_0, external_interrupt_line_3, spi2SckOut;
   logic spi2SckOe, spi2SckIn, spi2MisoOut, spi2MisoOe, spi2MisoIn;
   logic spi2MosiOut, spi2MosiOe, spi2MosiIn, spi2SselIn;
   logic pulse_width_output_5, can3_receive_line, can3_transmit_line;
   logic can2_receive_line, can2_transmit_line, can1_receive_line;
   logic [31:0] word;
   int n_errors = 0, cmp_count = 0, cycCount = 0;

   p0ps_pin_mux u_p0ps_pin_mux (.clock, .sys_rst, .wb_adr_i, .wb_dat_i,
      .wb_sel_i, .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_dat_o, .wb_ack_o,
      .gpioOut, .gpioDir, .gpioIn, .padIn, .padOut, .padOe, .timer0Match,
      .timer0Capture, .timer1Match, .timer1Capture,
      .external_interrupt_line_0, .external_interrupt_line_3, .spi2SckOut,
      .spi2SckOe, .spi2SckIn, .spi2MisoOut, .spi2MisoOe, .spi2MisoIn,
      .spi2MosiOut, .spi2MosiOe, .spi2MosiIn, .spi2SselIn,
      .pulse_width_output_5, .can3_receive_line, .can3_transmit_line,
      .can2_receive_line, .can2_transmit_line, .can1_receive_line,
      .analogSelect);
   p0ps_periph_model u_p0ps_periph_model (.clock, .sys_rst, .timer0Match,
      .timer1Match, .spi2SckOut, .spi2SckOe, .spi2MisoOut, .spi2MisoOe,
      .spi2MosiOut, .spi2MosiOe, .pulse_width_output_5,
      .can3_transmit_line, .can2_transmit_line);

   // Clock and hang guard; a full run needs well under 1000 cycles
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cycCount++;
      if (cycCount == 5000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   // One classic cycle; request held until ack is sampled
   task automatic wb(input logic we, input logic [31:0] a, d,
                     input logic [3:0] s, output logic [31:0] q);
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      @(posedge clock);
      while (wb_ack_o !== 1'b1) @(posedge clock);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
      logic [31:0] q;
      wb(1'b1, a, d, s, q);
      @(negedge clock);
   endtask

   task automatic rdc(input logic [31:0] a, e);
      logic [31:0] q;
      wb(1'b0, a, 32'h00000000, 4'hf, q);
      chk(q === e, "read data");
      @(negedge clock);
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence: reset, table, then the awkward cases
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      rdc(HI, 32'h15400000);
      chk(analogSelect === 4'hf, "reset analog");
      $display("test reset done");
      foreach (rows[i]) begin
         wr(HI, rows[i].d, rows[i].s);
         rdc(HI, rows[i].r);
         chk(analogSelect === rows[i].a, "analog select");
      end
      $display("test table done");
      wr(32'he002c000, 32'hffffffff, 4'hf);
      rdc(32'he002c000, 32'h00000000);
      rdc(HI, 32'h15402aff);
      $display("test unmapped done");
      wr(HI, 32'h00000000, 4'hf);
      @(posedge clock);
      gpioDir <= 16'h5a5a;
      @(negedge clock);
      chk(padOe === 16'h5a5a, "GPIO direction");
      chk(padOut === (gpioOut & 16'h7bff), "GPIO out");
      chk(gpioIn === padIn, "GPIO in");
      $display("test gpio done");
      for (int c = 1; c < 4; c++) begin
         word = {16{c[1:0]}} & (c == 1 ? 32'h3fcfffff
                                       : 32'h3fc03fff);
         @(posedge clock);
         padIn <= ~padIn;
         gpioDir <= ~gpioDir;
         wr(HI, word, 4'hf);
         if (c == 1) begin
            chk(padOe[6] === 1'b1 && padOut[6] === can3_transmit_line,
                "CAN 3 transmit");
            chk(external_interrupt_line_0 === padIn[0] && !padOe[0],
                "interrupt 0 in");
            chk(can1_receive_line === padIn[9], "CAN 1 in");
            chk(padOut[5] === pulse_width_output_5, "pwm out");
            chk(can2_receive_line === padIn[7], "CAN 2 in");
            chk(timer1Capture[2] === padIn[1], "capture 1.2");
         end else if (c == 2) begin
            chk(timer0Capture[0] === padIn[6], "capture 0.0");
            chk(padOut[0] === timer0Match[2], "match 0.2");
            chk(spi2SckIn === padIn[1] && padOe[1] === spi2SckOe,
                "serial clock");
            chk(can3_receive_line === padIn[5], "CAN 3 in");
            chk(spi2MisoIn === padIn[2], "MISO in");
            chk(spi2MosiIn === padIn[3], "MOSI in");
            chk(spi2SselIn === padIn[4], "select in");
            chk(timer0Capture[1] === padIn[11], "capture 0.1");
            chk(external_interrupt_line_3 === padIn[14], "int 3b");
         end else begin
            chk(timer0Capture[2] === padIn[0], "capture 0.2");
            chk(padOut[6] === timer0Match[0], "match 0.0");
            chk(external_interrupt_line_3 === padIn[4], "int 3");
            chk(padOut[2:1] === timer1Match, "match 1.x");
            chk(timer1Capture[3] === padIn[5], "capture 1.3");
         end
      end
      $display("test codes done");
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      rdc(HI, 32'h15400000);
      chk(analogSelect === 4'hf, "analog after reset");
      $display("test reset again done");
      end_of_test();
   end
endmodule // p0ps_pin_mux_tb_top

// ### logic/p0ps_pin_cell.v
// Purpose: One pin of the upper port 0 function multiplexer
// Assumes: Function slot 0 is GPIO; slots 1..3 are peripherals
// Notes:   Reserved codes leave the pin undriven and unrouted
`timescale 1ns/100ps
`include "p0ps_regs.vh"

module p0ps_pin_cell (
   // Selection
   input  wire [1:0] fieldSel,
   input  wire [3:0] legalCodes,
   // GPIO side
   input  wire       gpioOut,
   input  wire       gpioDir,
   // Peripheral side, slot 0 unused
   input  wire [3:0] fnOut,
   input  wire [3:0] fnOe,
   // Pad
   input  wire       padIn,
   output reg        padOut,
   output reg        padOe,
   // Decoded selection and routed input
   output wire [3:0] codeHit,
   output wire [3:0] fnIn
);

   // One-hot decode, masked by what this pin offers
   wire [3:0] rawHit;
   assign rawHit = 4'h1 << fieldSel;
   assign codeHit = rawHit & legalCodes;         // [RULE4]

   // Pad input reaches only the selected peripheral
   assign fnIn = codeHit & {4{padIn}};

   // Output path and direction per selected function
   always @* begin
      padOut = 1'b0;
      padOe  = 1'b0;
      if (codeHit[`P0PS_G]) begin
         padOut = gpioOut;
         padOe  = gpioDir;                       // [RULE2]
      end else if (|codeHit) begin
         padOut = |(fnOut & codeHit);
         padOe  = |(fnOe & codeHit);             // [RULE3]
      end
   end

endmodule // p0ps_pin_cell

// ### logic/p0ps_pin_mux.v
// Purpose: Function select register and pin routing for port 0
//          pins 16 to 31, reached over classic Wishbone
// Assumes: One clock; pad and peripheral signals are synchronous
// Notes:   Pin mux paths are combinational; bus data is registered
//          Reserved codes float the pad and route nothing, the
//          safest reading of codes whose effect is undefined
//
// Notes on behaviour
// [RULE1]: 32-bit select word, two bits per pin
// [RULE2]: GPIO direction bit only acts in GPIO mode
// [RULE3]: Peripheral modes take output enable from peripheral
// [RULE4]: Software avoids reserved codes; undefined otherwise
// [RULE5]: Pin 16: GPIO, irq0, T0 match2, T0 cap2
// [RULE6]: Pin 17: GPIO, T1 cap2, SPI2 clock, T1 match2
// [RULE7]: Pin 18: GPIO, T1 cap3, SPI2 MISO, T1 match3
// [RULE8]: Pin 19: GPIO, T1 match2, SPI2 MOSI, T1 cap2
// [RULE9]: Pin 20: GPIO, T1 match3, SPI2 select, irq3
// [RULE10]: Pin 21: GPIO, pulse out, CAN3 rx, T1 cap3
// [RULE11]: Pin 22: GPIO, CAN3 transmit, T0 cap0, match0
// [RULE12]: Pin 23: GPIO or CAN2 receive only
// [RULE13]: Pin 24: GPIO or CAN2 transmit only
// [RULE14]: Pin 25: GPIO or CAN1 receive only
// [RULE15]: Pins 26 and 31 offer no function
// [RULE16]: Pin 27: GPIO, analog 0, T0 cap1, match1
// [RULE17]: Pin 28: GPIO, analog 1, T0 cap2, match2
// [RULE18]: Pin 29: GPIO, analog 2, T0 cap3, match3
// [RULE19]: Pin 30: GPIO, analog 3, irq3, T0 cap0
// [RULE20]: Pins 27 to 30 reset to analog
// [RULE21]: Lower pins use a separate companion register
// [RULE22]: Whole word reads back last written value
`timescale 1ns/100ps
`include "p0ps_regs.vh"

module p0ps_pin_mux (
   // System
   input  wire        clock,
   input  wire        sys_rst,
   // Wishbone slave
   input  wire [31:0] wb_adr_i,
   input  wire [31:0] wb_dat_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_we_i,
   input  wire        wb_stb_i,
   input  wire        wb_cyc_i,
   output reg  [31:0] wb_dat_o,
   output wire        wb_ack_o,
   // GPIO block, upper sixteen bits
   input  wire [15:0] gpioOut,
   input  wire [15:0] gpioDir,
   output wire [15:0] gpioIn,
   // Pads 16..31
   input  wire [15:0] padIn,
   output wire [15:0] padOut,
   output wire [15:0] padOe,
   // Timer 0
   input  wire [3:0]  timer0Match,
   output wire [3:0]  timer0Capture,
   // Timer 1, channels 2 and 3
   input  wire [3:2]  timer1Match,
   output wire [3:2]  timer1Capture,
   // External interrupts
   output wire        external_interrupt_line_0,
   output wire        external_interrupt_line_3,
   // Second serial peripheral port
   input  wire        spi2SckOut,
   input  wire        spi2SckOe,
   output wire        spi2SckIn,
   input  wire        spi2MisoOut,
   input  wire        spi2MisoOe,
   output wire        spi2MisoIn,
   input  wire        spi2MosiOut,
   input  wire        spi2MosiOe,
   output wire        spi2MosiIn,
   output wire        spi2SselIn,
   // Pulse width output
   input  wire        pulse_width_output_5,
   // CAN controllers
   output wire        can3_receive_line,
   input  wire        can3_transmit_line,
   output wire        can2_receive_line,
   input  wire        can2_transmit_line,
   output wire        can1_receive_line,
   // Analog input selection, high disables digital use
   output wire [3:0]  analogSelect
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // Field k of the select word
   function [1:0] fieldOf;
      input [31:0] word;
      input integer k;
      begin
         fieldOf = word[k*`P0PS_FIELD_W +: `P0PS_FIELD_W];
      end
   endfunction

   // Address decode, used by write and read paths
   function hitHighSel;
      input [31:0] adr;
      begin
         hitHighSel = (adr == `P0PS_ADDR_HIGH_SEL);
      end
   endfunction

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   localparam [1:0] ST_IDLE = `P0PS_ST_IDLE;
   localparam [1:0] ST_ACK  = `P0PS_ST_ACK;

   // Reset word as a parameter, so each byte lane slices it
   localparam [31:0] HIGH_SEL_RST = `P0PS_HIGH_SEL_RST;

   reg  [1:0]  busState;
   reg  [1:0]  next_busState;
   reg  [31:0] highSel;
   wire        busReq;
   wire        take;
   wire        selHit;

   // Requests are taken only from idle; the cycle after ack is
   // always idle, which gives the master time to drop stb
   assign busReq = wb_cyc_i & wb_stb_i;
   assign take   = busReq & busState[0];
   assign selHit = hitHighSel(wb_adr_i);          // [RULE1]
   assign wb_ack_o = busState[1];

   // Answer one cycle after taking, then drop for one cycle
   always @* begin
      case (busState)
         ST_IDLE: next_busState = busReq ? ST_ACK : ST_IDLE;
         ST_ACK:  next_busState = ST_IDLE;
         default: next_busState = ST_IDLE;
      endcase
   end

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         busState <= ST_IDLE;
      end else begin
         busState <= next_busState;
      end
   end

   // Select word; byte lanes honoured, whole word storable
   // The companion low-pin word is not decoded here [RULE21]
   genvar b;
   generate
      for (b = 0; b < `P0PS_SEL_W; b = b + 1) begin : gLane
         always @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               highSel[b*8 +: 8] <= HIGH_SEL_RST[b*8 +: 8]; // [RULE20]
            end else if (take & wb_we_i & selHit & wb_sel_i[b]) begin
               highSel[b*8 +: 8] <= wb_dat_i[b*8 +: 8]; // [RULE22]
            end
         end
      end
   endgenerate

   // Read data latched with the answer; unmapped reads give zero
   // It is reloaded on every taken cycle, writes included, and never shows live pin levels
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wb_dat_o <= `P0PS_ZERO_WORD;
      end else if (take) begin
         wb_dat_o <= selHit ? highSel
                            : `P0PS_ZERO_WORD;    // [RULE22]
      end
   end

   // ------------------------------------------------------------
   // Per-pin function tables, slot order {f3, f2, f1, gpio}
   // ------------------------------------------------------------
   wire [3:0] fo16, fo17, fo18, fo19, fo20, fo21, fo22, fo23;
   wire [3:0] fo24, fo25, fo26, fo27, fo28, fo29, fo30, fo31;
   wire [3:0] fe16, fe17, fe18, fe19, fe20, fe21, fe22, fe23;
   wire [3:0] fe24, fe25, fe26, fe27, fe28, fe29, fe30, fe31;

   // Output-only slots drive their enable high, input-only
   // slots low; the serial lines keep their controller's
   // enable, since that controller decides when it drives
   
   // Pin 16: interrupt in, match out, capture in
   assign fo16 = {1'b0, timer0Match[2], 1'b0, 1'b0};      // [RULE5]
   assign fe16 = {1'b0, 1'b1, 1'b0, 1'b0};

   // Pin 17: capture in, clock both ways, match out
   assign fo17 = {timer1Match[2], spi2SckOut, 1'b0, 1'b0}; // [RULE6]
   assign fe17 = {1'b1, spi2SckOe, 1'b0, 1'b0};

   // Pin 18: capture in, MISO both ways, match out
   assign fo18 = {timer1Match[3], spi2MisoOut, 1'b0, 1'b0};// [RULE7]
   assign fe18 = {1'b1, spi2MisoOe, 1'b0, 1'b0};

   // Pin 19: match out, MOSI both ways, capture in
   assign fo19 = {1'b0, spi2MosiOut, timer1Match[2], 1'b0};// [RULE8]
   assign fe19 = {1'b0, spi2MosiOe, 1'b1, 1'b0};

   // Pin 20: match out, select in, interrupt in
   assign fo20 = {1'b0, 1'b0, timer1Match[3], 1'b0};      // [RULE9]
   assign fe20 = {1'b0, 1'b0, 1'b1, 1'b0};

   // Pin 21: PWM out, CAN receive in, capture in
   assign fo21 = {1'b0, 1'b0, pulse_width_output_5, 1'b0};// [RULE10]
   assign fe21 = {1'b0, 1'b0, 1'b1, 1'b0};

   // Pin 22: CAN transmit out, capture in, match out
   assign fo22 = {timer0Match[0], 1'b0, can3_transmit_line,
                  1'b0};                                   // [RULE11]
   assign fe22 = {1'b1, 1'b0, 1'b1, 1'b0};

   // Pin 23: CAN 2 receive in, upper codes reserved
   assign fo23 = 4'h0;                                     // [RULE12]
   assign fe23 = 4'h0;

   // Pin 24: CAN 2 transmit out
   assign fo24 = {1'b0, 1'b0, can2_transmit_line, 1'b0};  // [RULE13]
   assign fe24 = {1'b0, 1'b0, 1'b1, 1'b0};

   // Pin 25: CAN 1 receive in
   assign fo25 = 4'h0;                                     // [RULE14]
   assign fe25 = 4'h0;

   // Pins 26 and 31 carry nothing
   assign fo26 = 4'h0;                                     // [RULE15]
   assign fe26 = 4'h0;
   assign fo31 = 4'h0;
   assign fe31 = 4'h0;

   // Pins 27..29: analog, capture in, match out
   assign fo27 = {timer0Match[1], 1'b0, 1'b0, 1'b0};      // [RULE16]
   assign fe27 = {1'b1, 1'b0, 1'b0, 1'b0};
   assign fo28 = {timer0Match[2], 1'b0, 1'b0, 1'b0};      // [RULE17]
   assign fe28 = {1'b1, 1'b0, 1'b0, 1'b0};
   assign fo29 = {timer0Match[3], 1'b0, 1'b0, 1'b0};      // [RULE18]
   assign fe29 = {1'b1, 1'b0, 1'b0, 1'b0};

   // Pin 30: analog, interrupt in, capture in; all inputs
   assign fo30 = 4'h0;                                     // [RULE19]
   assign fe30 = 4'h0;

   wire [63:0] fnOutAll;
   wire [63:0] fnOeAll;
   wire [63:0] legalAll;

   // Flattened, pin 16 in the lowest nibble
   assign fnOutAll = {fo31, fo30, fo29, fo28, fo27, fo26, fo25, fo24,
                      fo23, fo22, fo21, fo20, fo19, fo18, fo17, fo16};
   assign fnOeAll  = {fe31, fe30, fe29, fe28, fe27, fe26, fe25, fe24,
                      fe23, fe22, fe21, fe20, fe19, fe18, fe17, fe16};

   // Reserved codes are masked off, so the pin floats [RULE4]
   assign legalAll = {`P0PS_LEGAL_NONE, `P0PS_LEGAL_ALL,
                      `P0PS_LEGAL_ALL,  `P0PS_LEGAL_ALL,
                      `P0PS_LEGAL_ALL,  `P0PS_LEGAL_NONE,
                      `P0PS_LEGAL_TWO,  `P0PS_LEGAL_TWO,
                      `P0PS_LEGAL_TWO,  `P0PS_LEGAL_ALL,
                      `P0PS_LEGAL_ALL,  `P0PS_LEGAL_ALL,
                      `P0PS_LEGAL_ALL,  `P0PS_LEGAL_ALL,
                      `P0PS_LEGAL_ALL,  `P0PS_LEGAL_ALL};

   // ------------------------------------------------------------
   // Pin cells
   // ------------------------------------------------------------
   wire [63:0] hitAll;
   wire [63:0] inAll;

   // Pins 26 and 31 have no legal code, GPIO included, so
   // their pads stay undriven whatever the field holds
   genvar k;
   generate
      for (k = 0; k < `P0PS_PINS; k = k + 1) begin : gPin
         p0ps_pin_cell uCell (
            .fieldSel   (fieldOf(highSel, k)),   // [RULE1]
            .legalCodes (legalAll[k*4 +: 4]),
            .gpioOut    (gpioOut[k]),
            .gpioDir    (gpioDir[k]),            // [RULE2]
            .fnOut      (fnOutAll[k*4 +: 4]),
            .fnOe       (fnOeAll[k*4 +: 4]),     // [RULE3]
            .padIn      (padIn[k]),
            .padOut     (padOut[k]),
            .padOe      (padOe[k]),
            .codeHit    (hitAll[k*4 +: 4]),
            .fnIn       (inAll[k*4 +: 4])
         );
      end
   endgenerate

   // GPIO always sees the pad level
   assign gpioIn = padIn;

   // ------------------------------------------------------------
   // Routed peripheral inputs
   // ------------------------------------------------------------
   wire [3:0] in16, in17, in18, in19, in20, in21, in22, in23;
   wire [3:0] in24, in25, in26, in27, in28, in29, in30, in31;
   wire [3:0] ht27, ht28, ht29, ht30;

   assign {in31, in30, in29, in28, in27, in26, in25, in24,
           in23, in22, in21, in20, in19, in18, in17, in16} = inAll;
   assign ht27 = hitAll[44 +: 4];
   assign ht28 = hitAll[48 +: 4];
   assign ht29 = hitAll[52 +: 4];
   assign ht30 = hitAll[56 +: 4];

   // Several pins may feed one input; they are ORed, so an
   // idle deselected pin never masks an active one
   assign external_interrupt_line_0 = in16[`P0PS_F1];     // [RULE5]
   assign external_interrupt_line_3 = in20[`P0PS_F3]      // [RULE9]
                                    | in30[`P0PS_F2];     // [RULE19]

   assign timer0Capture[0] = in22[`P0PS_F2]               // [RULE11]
                           | in30[`P0PS_F3];              // [RULE19]
   assign timer0Capture[1] = in27[`P0PS_F2];              // [RULE16]
   assign timer0Capture[2] = in16[`P0PS_F3]               // [RULE5]
                           | in28[`P0PS_F2];              // [RULE17]
   assign timer0Capture[3] = in29[`P0PS_F2];              // [RULE18]

   assign timer1Capture[2] = in17[`P0PS_F1]               // [RULE6]
                           | in19[`P0PS_F3];              // [RULE8]
   assign timer1Capture[3] = in18[`P0PS_F1]               // [RULE7]
                           | in21[`P0PS_F3];              // [RULE10]

   assign spi2SckIn  = in17[`P0PS_F2];                    // [RULE6]
   assign spi2MisoIn = in18[`P0PS_F2];                    // [RULE7]
   assign spi2MosiIn = in19[`P0PS_F2];                    // [RULE8]
   assign spi2SselIn = in20[`P0PS_F2];                    // [RULE9]

   assign can3_receive_line = in21[`P0PS_F2];             // [RULE10]
   assign can2_receive_line = in23[`P0PS_F1];             // [RULE12]
   assign can1_receive_line = in25[`P0PS_F1];             // [RULE14]

   // ------------------------------------------------------------
   // Analog channels
   // ------------------------------------------------------------
   // Code 01 on pins 27..30 hands the pad to the converter
   assign analogSelect = {ht30[`P0PS_F1], ht29[`P0PS_F1],
                          ht28[`P0PS_F1],
                          ht27[`P0PS_F1]};                 // [RULE20]

endmodule // p0ps_pin_mux

// ### logic/p0ps_regs.vh
// Purpose: Constants for the port 0 upper pin function select block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Definitions only; included by bare name
`ifndef P0PS_REGS_VH
`define P0PS_REGS_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define P0PS_ADDR_HIGH_SEL  32'he002c004
`define P0PS_ADDR_LOW_SEL   32'he002c000
`define P0PS_DATA_W         32
`define P0PS_SEL_W          4
`define P0PS_ZERO_WORD      32'h00000000

// Pins 27..30 reset to analog (code 01), all others to 00
`define P0PS_HIGH_SEL_RST   32'h15400000

// ---------------------------------------------------------------
// Field layout and codes
// ---------------------------------------------------------------
`define P0PS_PINS           16
`define P0PS_FIELD_W        2
`define P0PS_CODES          4
`define P0PS_CODE_GPIO      2'h0
`define P0PS_CODE_F1        2'h1
`define P0PS_CODE_F2        2'h2
`define P0PS_CODE_F3        2'h3
`define P0PS_G              0
`define P0PS_F1             1
`define P0PS_F2             2
`define P0PS_F3             3

// Legal code masks, bit n set when code n is offered
`define P0PS_LEGAL_ALL      4'hf
`define P0PS_LEGAL_TWO      4'h3
`define P0PS_LEGAL_NONE     4'h0

// ---------------------------------------------------------------
// Bus answer state, one-hot
// ---------------------------------------------------------------
`define P0PS_ST_IDLE        2'h1
`define P0PS_ST_ACK         2'h2

`endif
